// file: hdl/flhc_cycle.sv
// One bus cycle (write pulse or read sample) on the flash pins.
// Assumes the data input pins are already synchronised by the caller.
`timescale 1ns/10ps
`include "flhc_defines.svh"
module flhc_cycle
    import flhc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic start_i,
    input wire logic write_i,
    input wire logic [19:0] addr_i,
    input wire logic [7:0] data_i,
    input wire logic [7:0] rd_data_i,
    output logic busy_o,
    output logic done_o,
    output logic [7:0] rd_data_o,
    output flhc_bus_t bus_o
);
    typedef enum logic [2:0] {
        FLHC_CY_IDLE = 3'b001,
        FLHC_CY_LOW = 3'b010,
        FLHC_CY_HIGH = 3'b100
    } flhc_cy_t;

    flhc_cy_t st_reg, st_next;
    logic [`FLHC_CNT_W-1:0] cnt_reg, cnt_next;
    logic wr_reg, wr_next;
    logic [7:0] rd_reg, rd_next;
    flhc_bus_t bus_reg, bus_next;

    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        wr_next = wr_reg;
        rd_next = rd_reg;
        bus_next = bus_reg;
        done_o = 1'b0;
        case (st_reg)
            FLHC_CY_IDLE: begin
                if (start_i) begin
                    wr_next = write_i;
                    bus_next.addr = addr_i;
                    bus_next.data = data_i;
                    bus_next.drive = write_i;
                    // Both strobes fall together so the write begins at one edge. [RL9]
                    bus_next.ce_n = 1'b0;
                    bus_next.we_n = !write_i;
                    bus_next.oe_n = write_i;
                    // Reads stay low longer so the synchronised data has settled when sampled.
                    if (write_i) begin
                        cnt_next = `FLHC_CNT_W'(`FLHC_WP_CYC);
                    end else begin
                        cnt_next = `FLHC_CNT_W'(`FLHC_RD_CYC);
                    end
                    st_next = FLHC_CY_LOW;
                end
            end
            FLHC_CY_LOW: begin
                if (cnt_reg > `FLHC_CNT_W'(1)) begin
                    cnt_next = cnt_reg - `FLHC_CNT_W'(1);
                end else begin
                    rd_next = rd_data_i;
                    // Write ends when the first strobe rises; data stays for hold. [RL9]
                    bus_next.we_n = 1'b1;
                    bus_next.ce_n = 1'b1;
                    bus_next.oe_n = 1'b1;
                    cnt_next = `FLHC_CNT_W'(`FLHC_WPH_CYC);
                    st_next = FLHC_CY_HIGH;
                end
            end
            FLHC_CY_HIGH: begin
                if (cnt_reg > `FLHC_CNT_W'(1)) begin
                    cnt_next = cnt_reg - `FLHC_CNT_W'(1);
                end else begin
                    bus_next.drive = 1'b0;
                    done_o = 1'b1;
                    st_next = FLHC_CY_IDLE;
                end
            end
            default: st_next = FLHC_CY_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_reg <= FLHC_CY_IDLE;
            cnt_reg <= '0;
            wr_reg <= 1'b0;
            rd_reg <= '0;
            bus_reg <= '{addr: 20'h0, data: 8'h0, oe_n: 1'b1, ce_n: 1'b1, we_n: 1'b1,
                         drive: 1'b0};
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            bus_reg <= bus_next;
        end
    end

    assign busy_o = (st_reg != FLHC_CY_IDLE);
    assign rd_data_o = rd_reg;
    assign bus_o = bus_reg;

    AST_WE_WITH_CE: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !bus_reg.we_n |-> !bus_reg.ce_n) else $error("write strobe low without chip select"); // [RL9]
    AST_WE_PULSE: assert property (@(posedge clk_i) disable iff (!rstn_i)
        $fell(bus_reg.we_n) |-> !bus_reg.we_n [*2]) else $error("write pulse too short"); // [RL9]
endmodule

// file: hdl/flhc_defines.svh
// Timing, command and field constants for the flash host controller.
// Assumes a 25 MHz system clock.
`ifndef FLHC_DEFINES_SVH
`define FLHC_DEFINES_SVH
`define FLHC_CLK_NS 40
`define FLHC_WP_NS 60
`define FLHC_WPH_NS 20
`define FLHC_LOCK_NS 100
`define FLHC_WP_CYC ((`FLHC_WP_NS + `FLHC_CLK_NS - 1) / `FLHC_CLK_NS)
`define FLHC_WPH_CYC ((`FLHC_WPH_NS + `FLHC_CLK_NS - 1) / `FLHC_CLK_NS)
`define FLHC_LOCK_CYC ((`FLHC_LOCK_NS + `FLHC_CLK_NS - 1) / `FLHC_CLK_NS)
`define FLHC_SYNC_STAGES 2
`define FLHC_RD_CYC (`FLHC_WP_CYC + `FLHC_SYNC_STAGES)
`define FLHC_CMD_READ_ARRAY 8'hff
`define FLHC_CMD_PROG_SETUP 8'h40
`define FLHC_CMD_ERASE_SETUP 8'h20
`define FLHC_CMD_CONFIRM 8'hd0
`define FLHC_CMD_SUSPEND 8'hb0
`define FLHC_CMD_READ_STATUS 8'h70
`define FLHC_CMD_CLEAR_STATUS 8'h50
`define FLHC_CMD_READ_ID 8'h90
`define FLHC_READY_BIT 7
`define FLHC_SUSP_BIT 6
`define FLHC_CNT_W 4
`endif

// file: hdl/flhc_host.sv
// Host-side controller for a clockless command-driven flash memory.
// Assumes flash data-out pins are asynchronous and are synchronised here.
// Summary of operation
// RL1 - After program setup, next write carries the data and address to program.
// RL2 - Device decodes read array, program, erase, status, identifier, clear commands.
// RL3 - Erase setup needs confirm next; anything else gives erase command error.
// RL4 - Suspend code pauses erase; confirm resumes; program and identifier are reserved.
// RL5 - During operation device ignores writes except suspend during erase.
// RL6 - Operation complete only when a status read shows the ready bit set.
// RL7 - Boot block writes keep unlock condition until successful completion.
// RL8 - Wait the boot lock delay after removing unlock before trusting lock.
// RL9 - Write is active only while chip select and write strobe are both low.
// RL10 - Device runs program and erase algorithms itself, including verification.
`timescale 1ns/10ps
`include "flhc_defines.svh"
module flhc_host
    import flhc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic req_valid_i,
    input flhc_req_t req_i,
    output logic req_ready_o,
    output logic resp_valid_o,
    output logic [7:0] resp_data_o,
    output logic erase_suspended_o,
    output logic [19:0] flash_addr_o,
    output logic [7:0] flash_dq_o,
    output logic flash_dq_oe_o,
    input wire logic [7:0] flash_dq_i,
    output logic flash_ce_n_o,
    output logic flash_we_n_o,
    output logic flash_oe_n_o,
    output logic write_protect_o,
    output logic reset_powerdown_n_o
);
    typedef enum logic [8:0] {
        FLHC_IDLE = 9'b000000001,
        FLHC_CMD = 9'b000000010,
        FLHC_DATA = 9'b000000100,
        FLHC_POLL_CMD = 9'b000001000,
        FLHC_POLL = 9'b000010000,
        FLHC_READ = 9'b000100000,
        FLHC_LOCK = 9'b001000000,
        FLHC_DONE = 9'b010000000,
        FLHC_SUSP_CMD = 9'b100000000
    } flhc_state_t;

    flhc_state_t st_reg, st_next;
    flhc_req_t req_reg, req_next;
    logic [7:0] resp_reg, resp_next;
    logic susp_reg, susp_next;
    logic wp_reg, wp_next;
    logic [`FLHC_CNT_W-1:0] lock_reg, lock_next;
    logic [7:0] dq_meta_reg, dq_sync_reg;
    logic cy_start, cy_write, cy_busy, cy_done;
    logic [19:0] cy_addr;
    logic [7:0] cy_data, cy_rd;
    flhc_bus_t bus;

    // -----------------------------------------------------------------
    // Pin synchroniser
    // -----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dq_meta_reg <= '0;
            dq_sync_reg <= '0;
        end else begin
            dq_meta_reg <= flash_dq_i;
            dq_sync_reg <= dq_meta_reg;
        end
    end

    flhc_cycle u_cycle (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .start_i(cy_start),
        .write_i(cy_write),
        .addr_i(cy_addr),
        .data_i(cy_data),
        .rd_data_i(dq_sync_reg),
        .busy_o(cy_busy),
        .done_o(cy_done),
        .rd_data_o(cy_rd),
        .bus_o(bus)
    );

    // -----------------------------------------------------------------
    // Command sequencer
    // -----------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        req_next = req_reg;
        resp_next = resp_reg;
        susp_next = susp_reg;
        wp_next = wp_reg;
        lock_next = lock_reg;
        cy_start = 1'b0;
        cy_write = 1'b1;
        cy_addr = req_reg.addr;
        cy_data = `FLHC_CMD_READ_ARRAY;
        case (st_reg)
            FLHC_IDLE: begin
                if (req_valid_i) begin
                    req_next = req_i;
                    // Unlock before the sequence when the target is the boot block. [RL7]
                    if (req_i.boot) begin
                        wp_next = 1'b1;
                    end
                    if (req_i.op == FLHC_OP_LOCK) begin
                        wp_next = 1'b0;
                        lock_next = `FLHC_CNT_W'(`FLHC_LOCK_CYC);
                        st_next = FLHC_LOCK;
                    end else begin
                        st_next = FLHC_CMD;
                    end
                end
            end
            FLHC_CMD: begin
                // The host never issues program or identifier while an erase is suspended. [RL4]
                case (req_reg.op) // [RL2]
                    FLHC_OP_PROGRAM: cy_data = `FLHC_CMD_PROG_SETUP;
                    FLHC_OP_ERASE: cy_data = `FLHC_CMD_ERASE_SETUP;
                    FLHC_OP_RESUME: cy_data = `FLHC_CMD_CONFIRM;
                    FLHC_OP_STATUS: cy_data = `FLHC_CMD_READ_STATUS;
                    FLHC_OP_CLEAR: cy_data = `FLHC_CMD_CLEAR_STATUS;
                    FLHC_OP_READ_ID: cy_data = `FLHC_CMD_READ_ID;
                    FLHC_OP_SUSPEND: cy_data = `FLHC_CMD_SUSPEND;
                    default: cy_data = `FLHC_CMD_READ_ARRAY;
                endcase
                if ((req_reg.op == FLHC_OP_PROGRAM || req_reg.op == FLHC_OP_READ_ID)
                        && susp_reg) begin
                    resp_next = 8'h00;
                    st_next = FLHC_DONE;
                end else begin
                    cy_start = !cy_busy;
                    if (cy_done) begin
                        case (req_reg.op)
                            // Next write after setup is the data itself. [RL1]
                            FLHC_OP_PROGRAM: st_next = FLHC_DATA;
                            // Erase confirm must be the very next write. [RL3]
                            FLHC_OP_ERASE: st_next = FLHC_DATA;
                            FLHC_OP_RESUME: begin
                                susp_next = 1'b0;
                                st_next = FLHC_POLL_CMD;
                            end
                            FLHC_OP_CLEAR: st_next = FLHC_DONE;
                            FLHC_OP_SUSPEND: st_next = FLHC_POLL_CMD;
                            default: st_next = FLHC_READ;
                        endcase
                    end
                end
            end
            FLHC_DATA: begin
                cy_data = (req_reg.op == FLHC_OP_ERASE) ? `FLHC_CMD_CONFIRM : req_reg.data;
                cy_start = !cy_busy;
                if (cy_done) begin
                    st_next = FLHC_POLL_CMD;
                end
            end
            FLHC_POLL_CMD: begin
                // Status is requested explicitly so polling also works after resume. [RL5]
                cy_data = `FLHC_CMD_READ_STATUS;
                cy_start = !cy_busy;
                if (cy_done) begin
                    st_next = FLHC_POLL;
                end
            end
            FLHC_POLL: begin
                cy_write = 1'b0;
                cy_start = !cy_busy;
                if (cy_done && cy_rd[`FLHC_READY_BIT]) begin
                    // Completion is taken only from a status read with the ready bit set. [RL6] [RL10]
                    resp_next = cy_rd;
                    if (req_reg.op == FLHC_OP_SUSPEND) begin
                        susp_next = cy_rd[`FLHC_SUSP_BIT];
                    end
                    st_next = FLHC_DONE;
                end
            end
            FLHC_READ: begin
                cy_write = 1'b0;
                cy_start = !cy_busy;
                if (cy_done) begin
                    resp_next = cy_rd;
                    st_next = FLHC_DONE;
                end
            end
            FLHC_LOCK: begin
                // Lock is reported only after the boot lock delay has run out. [RL8]
                if (lock_reg > `FLHC_CNT_W'(1)) begin
                    lock_next = lock_reg - `FLHC_CNT_W'(1);
                end else begin
                    st_next = FLHC_DONE;
                end
            end
            FLHC_DONE: begin
                st_next = FLHC_IDLE;
            end
            default: st_next = FLHC_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_reg <= FLHC_IDLE;
            req_reg <= '0;
            resp_reg <= '0;
            susp_reg <= 1'b0;
            wp_reg <= 1'b0;
            lock_reg <= '0;
        end else begin
            st_reg <= st_next;
            req_reg <= req_next;
            resp_reg <= resp_next;
            susp_reg <= susp_next;
            wp_reg <= wp_next;
            lock_reg <= lock_next;
        end
    end

    assign req_ready_o = (st_reg == FLHC_IDLE);
    assign resp_valid_o = (st_reg == FLHC_DONE);
    assign resp_data_o = resp_reg;
    assign erase_suspended_o = susp_reg;
    assign write_protect_o = wp_reg;
    assign reset_powerdown_n_o = rstn_i;
    assign flash_addr_o = bus.addr;
    assign flash_dq_o = bus.data;
    assign flash_dq_oe_o = bus.drive;
    assign flash_ce_n_o = bus.ce_n;
    assign flash_we_n_o = bus.we_n;
    assign flash_oe_n_o = bus.oe_n;

    sequence s_setup_done;
        st_reg == FLHC_CMD && cy_done && req_reg.op == FLHC_OP_PROGRAM;
    endsequence

    AST_PROG_DATA_NEXT: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_setup_done |=> st_reg == FLHC_DATA) else $error("program data not next"); // [RL1]
    AST_ERASE_CONFIRM: assert property (@(posedge clk_i) disable iff (!rstn_i)
        st_reg == FLHC_DATA && req_reg.op == FLHC_OP_ERASE && cy_start |=>
        flash_dq_o == `FLHC_CMD_CONFIRM) else $error("erase not confirmed"); // [RL3]
    AST_DONE_READY: assert property (@(posedge clk_i) disable iff (!rstn_i)
        $rose(resp_valid_o) && req_reg.op == FLHC_OP_PROGRAM && !erase_suspended_o |->
        resp_data_o[`FLHC_READY_BIT]) else $error("completion without ready bit"); // [RL6]
    AST_WP_HELD: assert property (@(posedge clk_i) disable iff (!rstn_i)
        st_reg == FLHC_POLL && req_reg.boot |-> write_protect_o) else $error("unlock dropped"); // [RL7]
    AST_LOCK_WAIT: assert property (@(posedge clk_i) disable iff (!rstn_i)
        $rose(st_reg == FLHC_LOCK) |-> !resp_valid_o [*3]) else $error("lock delay short"); // [RL8]
    AST_NO_PROG_SUSP: assert property (@(posedge clk_i) disable iff (!rstn_i)
        susp_reg && st_reg == FLHC_CMD && req_reg.op == FLHC_OP_PROGRAM |=>
        st_reg == FLHC_DONE) else $error("program issued while suspended"); // [RL4]
    AST_ONE_DONE: assert property (@(posedge clk_i) disable iff (!rstn_i)
        resp_valid_o |=> !resp_valid_o) else $error("response longer than one cycle"); // [RL2]
    AST_WE_CE: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !flash_we_n_o |-> !flash_ce_n_o && flash_dq_oe_o) else $error("bad write strobes"); // [RL9]
endmodule

// file: hdl/flhc_pkg.sv
// Types shared by the flash host controller files.
// Assumes the defines header is compiled alongside.
package flhc_pkg;
    typedef enum logic [3:0] {
        FLHC_OP_READ = 4'h0,
        FLHC_OP_PROGRAM = 4'h1,
        FLHC_OP_ERASE = 4'h2,
        FLHC_OP_SUSPEND = 4'h3,
        FLHC_OP_RESUME = 4'h4,
        FLHC_OP_STATUS = 4'h5,
        FLHC_OP_CLEAR = 4'h6,
        FLHC_OP_READ_ID = 4'h7,
        FLHC_OP_LOCK = 4'h8
    } flhc_op_t;

    typedef struct packed {
        flhc_op_t op;
        logic [19:0] addr;
        logic [7:0] data;
        logic boot;
    } flhc_req_t;

    typedef struct packed {
        logic [19:0] addr;
        logic [7:0] data;
        logic oe_n;
        logic ce_n;
        logic we_n;
        logic drive;
    } flhc_bus_t;
endpackage

// file: sim/flhc_flash_model.sv
// Behavioural model of the command-driven flash memory facing the host controller.
// Assumes the testbench ties its data output to the host data input pins.
`timescale 1ns/10ps
module flhc_flash_model
    import flhc_pkg::*;
#(
    parameter logic [7:0] MFR_ID = 8'h5a, // Arbitrary value.
    parameter logic [7:0] DEV_ID = 8'h3c, // Arbitrary value.
    parameter real WP_NS = 60.0,
    parameter real WPH_NS = 20.0,
    parameter real LOCK_NS = 100.0
)
(
    input wire logic reset_powerdown_n_i,
    input wire logic ce_n_i,
    input wire logic we_n_i,
    input wire logic oe_n_i,
    input wire logic write_protect_i,
    input wire logic [19:0] addr_i,
    input wire logic [7:0] dq_i,
    input wire logic dq_oe_i,
    input wire logic [3:0] busy_polls_i,
    output logic [7:0] dq_o,
    output logic [7:0] viol_o
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef enum {FS_READY, FS_PSETUP, FS_ESETUP, FS_PBUSY, FS_EBUSY, FS_SUSP} flhc_fst_t;
    flhc_fst_t st = FS_READY;
    logic [1:0] mode = 2'h0;
    logic [7:0] sr = 8'h00;
    logic [7:0] mem [int];
    logic [7:0] last = 8'h00;
    logic [3:0] polls = 4'h0;
    logic boot_busy = 1'b0;
    real t_low = 0.0;
    real t_high = -1000.0;
    real t_wp = -1000.0;
    wire wr = !ce_n_i && !we_n_i && reset_powerdown_n_i;
    wire rd = !ce_n_i && !oe_n_i && reset_powerdown_n_i;
    wire busy = (st == FS_PBUSY) || (st == FS_EBUSY);
    initial viol_o = 8'h00;

    function automatic logic is_boot(input logic [19:0] a);
        return a[19:14] == 6'h00;
    endfunction

    // ----------------------------------------
    // Write decode
    // ----------------------------------------
    always @(negedge reset_powerdown_n_i) begin
        st = FS_READY;
        mode = 2'h0;
        sr = 8'h00;
    end
    always @(negedge write_protect_i) begin
        if (boot_busy) viol_o = viol_o + 8'h01;
        t_wp = $realtime;
    end
    always @(posedge wr) begin
        if ($realtime - t_high < WPH_NS) viol_o = viol_o + 8'h01;
        t_low = $realtime;
    end
    always @(negedge wr) begin
        t_high = $realtime;
        if ($realtime - t_low < WP_NS || !dq_oe_i) viol_o = viol_o + 8'h01;
        if (is_boot(addr_i) && !write_protect_i && $realtime - t_wp < LOCK_NS)
            viol_o = viol_o + 8'h01;
        case (st)
            FS_PBUSY: ;
            FS_EBUSY: if (dq_i == 8'hb0) st = FS_SUSP;
            FS_PSETUP: begin
                // The write after setup is data, never a command.
                if (is_boot(addr_i) && !write_protect_i) sr = sr | 8'h10;
                else mem[addr_i] = (mem.exists(addr_i) ? mem[addr_i] : 8'hff) & dq_i;
                boot_busy = is_boot(addr_i);
                polls = busy_polls_i;
                st = FS_PBUSY;
            end
            FS_ESETUP: begin
                if (dq_i != 8'hd0) begin
                    sr = sr | 8'h30;
                    st = FS_READY;
                end else begin
                    if (is_boot(addr_i) && !write_protect_i) sr = sr | 8'h20;
                    else foreach (mem[k]) if (k[19:13] == addr_i[19:13]) mem[k] = 8'hff;
                    boot_busy = is_boot(addr_i);
                    polls = busy_polls_i;
                    st = FS_EBUSY;
                end
            end
            FS_SUSP: begin
                case (dq_i)
                    8'h70: mode = 2'h1;
                    8'hd0: st = FS_EBUSY;
                    8'h10, 8'h40, 8'h90: ;
                    default: mode = 2'h0;
                endcase
            end
            default: begin
                case (dq_i)
                    8'h10, 8'h40: st = FS_PSETUP;
                    8'h20: st = FS_ESETUP;
                    8'h70: mode = 2'h1;
                    8'h90: mode = 2'h2;
                    8'h50: begin
                        sr = 8'h00;
                        mode = 2'h0;
                    end
                    default: mode = 2'h0;
                endcase
                if (st != FS_READY) mode = 2'h1;
            end
        endcase
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    always @* begin
        if (rd) last = dq_o;
    end
    always @(negedge rd) begin
        // Each busy status read lets the algorithm advance one step.
        if (busy && mode == 2'h1) begin
            if (polls == 4'h0) begin
                st = FS_READY;
                boot_busy = 1'b0;
            end else polls = polls - 4'h1;
        end
    end
    // A released bus shows the inverse of the last byte, never a stale copy.
    always @* begin
        if (!rd) dq_o = ~last;
        else if (busy) dq_o = sr & 8'h7f;
        else if (mode == 2'h1) dq_o = sr | 8'h80 | ((st == FS_SUSP) ? 8'h40 : 8'h00);
        else if (mode == 2'h2) dq_o = addr_i[0] ? DEV_ID : MFR_ID;
        else dq_o = mem.exists(addr_i) ? mem[addr_i] : 8'hff;
    end
endmodule

// file: sim/tb_flash_command_state_machine.sv
// Self-checking bench for the flash host controller against the flash model.
// Assumes the design package, header and the flash model are compiled first.
`timescale 1ns/10ps
module tb_flash_command_state_machine;
    import flhc_pkg::*;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic req_valid_i = 1'b0;
    flhc_req_t req_i = '0;
    logic req_ready_o, resp_valid_o, erase_suspended_o, flash_dq_oe_o;
    logic [7:0] resp_data_o, flash_dq_o, flash_dq_i, viol;
    logic [19:0] flash_addr_o;
    logic flash_ce_n_o, flash_we_n_o, flash_oe_n_o, write_protect_o, reset_powerdown_n_o;
    logic [3:0] busy_polls = 4'h0;
    logic [8:0] exp_q [$];
    logic [8:0] item;
    logic [19:0] a;
    logic [7:0] d;
    int seed = 32'ha574;
    int n_fail = 0;
    int comparisons = 0;
    int n_req = 0;
    int n_resp = 0;

    always #20 clk_i = ~clk_i;

    flhc_host dut (.clk_i(clk_i), .rstn_i(rstn_i), .req_valid_i(req_valid_i), .req_i(req_i),
        .req_ready_o(req_ready_o), .resp_valid_o(resp_valid_o), .resp_data_o(resp_data_o),
        .erase_suspended_o(erase_suspended_o), .flash_addr_o(flash_addr_o),
        .flash_dq_o(flash_dq_o), .flash_dq_oe_o(flash_dq_oe_o), .flash_dq_i(flash_dq_i),
        .flash_ce_n_o(flash_ce_n_o), .flash_we_n_o(flash_we_n_o), .flash_oe_n_o(flash_oe_n_o),
        .write_protect_o(write_protect_o), .reset_powerdown_n_o(reset_powerdown_n_o));
    flhc_flash_model flash (.reset_powerdown_n_i(reset_powerdown_n_o), .ce_n_i(flash_ce_n_o),
        .we_n_i(flash_we_n_o), .oe_n_i(flash_oe_n_o), .write_protect_i(write_protect_o),
        .addr_i(flash_addr_o), .dq_i(flash_dq_o), .dq_oe_i(flash_dq_oe_o),
        .busy_polls_i(busy_polls), .dq_o(flash_dq_i), .viol_o(viol));

    // ----------------------------------------
    // Checking
    // ----------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] expv);
        comparisons++;
        if (seen !== expv) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, expv);
        end
    endtask
    task automatic test_done();
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(negedge clk_i) begin
        if (resp_valid_o === 1'b1) begin
            n_resp++;
            if (exp_q.size() == 0) begin
                n_fail++;
                $display("CHECK FAILED t=%0t seen=%h exp=none", $time, resp_data_o);
            end else begin
                item = exp_q.pop_front();
                if (item[8]) check(resp_data_o, item[7:0]);
            end
        end
    end

    // ----------------------------------------
    // Driving
    // ----------------------------------------
    // One request at a time: the next is offered only after the previous answer.
    task automatic req(input flhc_op_t op, input logic [19:0] ad, input logic [7:0] dt,
        input logic bt, input logic chk, input logic [7:0] e);
        int k;
        busy_polls = 4'($random(seed)) & 4'h7;
        k = 0;
        while (req_ready_o !== 1'b1 && k < 200) begin
            @(negedge clk_i);
            k++;
        end
        if (k >= 200) begin
            n_fail++;
            test_done();
        end
        exp_q.push_back({chk, e});
        n_req++;
        req_valid_i = 1'b1;
        req_i = '{op: op, addr: ad, data: dt, boot: bt};
        @(negedge clk_i);
        req_valid_i = 1'b0;
        k = 0;
        while (n_resp != n_req && k < 3000) begin
            @(negedge clk_i);
            k++;
        end
        if (k >= 3000) begin
            n_fail++;
            test_done();
        end
    endtask

    initial begin
        repeat (12) @(negedge clk_i);
        rstn_i = 1'b1;
        req(FLHC_OP_READ_ID, 20'h00000, 8'h00, 1'b0, 1'b1, 8'h5a);
        req(FLHC_OP_READ_ID, 20'h00001, 8'h00, 1'b0, 1'b1, 8'h3c);
        for (int i = 0; i < 4; i++) begin
            a = {4'h2, 16'($random(seed))};
            d = 8'($random(seed));
            req(FLHC_OP_PROGRAM, a, d, 1'b0, 1'b1, 8'h80);
            req(FLHC_OP_READ, a, 8'h00, 1'b0, 1'b1, d);
        end
        req(FLHC_OP_STATUS, a, 8'h00, 1'b0, 1'b1, 8'h80);
        req(FLHC_OP_ERASE, a, 8'h00, 1'b0, 1'b1, 8'h80);
        req(FLHC_OP_READ, a, 8'h00, 1'b0, 1'b1, 8'hff);
        req(FLHC_OP_LOCK, 20'h00010, 8'h00, 1'b0, 1'b0, 8'h00);
        check({7'h0, write_protect_o}, 8'h00);
        req(FLHC_OP_PROGRAM, 20'h00010, 8'h12, 1'b0, 1'b1, 8'h90);
        req(FLHC_OP_READ, 20'h00010, 8'h00, 1'b0, 1'b1, 8'hff);
        req(FLHC_OP_CLEAR, 20'h00000, 8'h00, 1'b0, 1'b0, 8'h00);
        req(FLHC_OP_STATUS, 20'h00000, 8'h00, 1'b0, 1'b1, 8'h80);
        req(FLHC_OP_PROGRAM, 20'h00010, 8'h5c, 1'b1, 1'b1, 8'h80);
        check({7'h0, write_protect_o}, 8'h01);
        check({7'h0, reset_powerdown_n_o}, 8'h01);
        req(FLHC_OP_SUSPEND, 20'h00010, 8'h00, 1'b0, 1'b1, 8'h80);
        check({7'h0, erase_suspended_o}, 8'h00);
        req(FLHC_OP_RESUME, 20'h00010, 8'h00, 1'b0, 1'b0, 8'h00);
        req(FLHC_OP_READ, 20'h00010, 8'h00, 1'b0, 1'b1, 8'h5c);
        check(viol, 8'h00);
        test_done();
    end
endmodule
